// ---- hdl/bus_activity_profiler.sv ----
// Bus activity profiler: debug state port for the split-transfer port and
// 32-bit event counters for the instruction, split-transfer and DMA layers.
// Assumes all monitored signals and the Wishbone master share clk_i.
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps

module bus_activity_profiler #(
  parameter logic [31:0] BASE_ADDR = profiler_pkg::MON_BASE_ADDR
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [profiler_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  input  wire profiler_pkg::ahb_mon_s        instr_bus_i,
  input  wire logic                          debug_acknowledge_i,
  input  wire profiler_pkg::ahb_mon_s        dma_bus_i,
  input  wire profiler_pkg::split_mon_s      split_transfer_port_i,
  output logic      [3:0]                    bus_state_debug_port_o
);

  profiler_pkg::prof_state_s s_q;
  profiler_pkg::prof_state_s s_d;

  logic [profiler_pkg::NCNT-1:0][31:0] preset_val;
  logic [profiler_pkg::NCNT-1:0]       inc;
  logic [profiler_pkg::NCNT-1:0]       cnt_en;
  logic                                req;
  logic                                i_en;
  logic                                g_en;
  logic                                i_done;
  logic                                d_done;
  logic                                rd_addr_hs;
  logic                                rd_data_hs;
  logic [31:0]                         rd_mux;
  logic [3:0]                          cnt_idx;

  // ----------------------------------------------------------------------
  // Preset values: each counter's own absolute address
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < profiler_pkg::NCNT; g++) begin : g_preset
    assign preset_val[g] = BASE_ADDR + {20'h00000, profiler_pkg::OFS_CNT_BASE}
                           + 32'(g * 4);
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  assign cnt_idx = wb_adr_i[5:2];

  always_comb begin
    rd_mux = 32'h00000000;
    if (wb_adr_i[1:0] == 2'h0) begin
      if (wb_adr_i[11:8] == profiler_pkg::CNT_PAGE && wb_adr_i[7:6] == 2'h0) begin
        rd_mux = s_q.cnt[cnt_idx];
      end else begin
        unique case (wb_adr_i)
          profiler_pkg::OFS_CTRL:   rd_mux = {30'h00000000, s_q.ctrl};
          profiler_pkg::OFS_THRESH: rd_mux = {16'h0000, s_q.thresh};
          profiler_pkg::OFS_DEBUG:  rd_mux = {28'h0000000, s_q.dbg};
          default:                  rd_mux = 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    inc        = '0;
    cnt_en     = '0;
    rd_addr_hs = 1'b0;
    rd_data_hs = 1'b0;
    i_done     = 1'b0;
    d_done     = 1'b0;

    // Registered copies of the monitored buses
    s_d.instr_r  = instr_bus_i;
    s_d.dma_r    = dma_bus_i;
    s_d.split_r  = split_transfer_port_i;
    s_d.debug_acknowledge_r = debug_acknowledge_i;

    // Control delayed by the monitor pipeline depth
    s_d.ctrl_eff    = s_q.ctrl;
    s_d.thresh_eff  = s_q.thresh;
    s_d.clear_pend  = 1'b0;
    s_d.preset_pend = 1'b0;

    // Wishbone slave, one wait cycle, unmapped reads as zero
    req       = wb_cyc_i & wb_stb_i & ~s_q.ack;
    s_d.ack   = req;
    s_d.rdata = 32'h00000000;
    if (req && wb_we_i && wb_adr_i[1:0] == 2'h0) begin
      unique case (wb_adr_i)
        profiler_pkg::OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            s_d.ctrl = wb_dat_i[1:0];
          end
        end
        profiler_pkg::OFS_THRESH: begin
          if (wb_sel_i[0]) begin
            s_d.thresh[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            s_d.thresh[15:8] = wb_dat_i[15:8];
          end
        end
        profiler_pkg::OFS_CLEAR:  s_d.clear_pend  = 1'b1;
        profiler_pkg::OFS_PRESET: s_d.preset_pend = 1'b1;
        default: ;
      endcase
    end
    if (req && !wb_we_i) begin
      s_d.rdata = rd_mux;
    end

    g_en = s_q.ctrl_eff[profiler_pkg::CTRL_EN_BIT];
    i_en = g_en & ~(s_q.ctrl_eff[profiler_pkg::CTRL_TRACK_BIT] & s_q.debug_acknowledge_r);

    // ------------------------------------------------------------------
    // Instruction layer
    // ------------------------------------------------------------------
    if (s_q.i_dp_valid) begin
      if (!s_q.instr_r.hready) begin
        s_d.i_run = (s_q.i_run == '1) ? s_q.i_run : s_q.i_run + 16'h0001;
        if (s_q.instr_r.hresp == profiler_pkg::RESP_OKAY) begin
          inc[profiler_pkg::C_INSTR_WAIT_TOTAL_COUNT] = 1'b1;
          if (s_q.i_dp_first) begin
            if (!s_q.instr_r.slave_ready) begin
              inc[profiler_pkg::C_INSTR_FIRST_WAIT_SLAVE_COUNT] = 1'b1;
            end else begin
              inc[profiler_pkg::C_INSTR_FIRST_WAIT_FABRIC_COUNT] = 1'b1;
            end
          end
          if (s_q.i_run == s_q.thresh_eff) begin
            inc[profiler_pkg::C_INSTR_WAIT_THRESHOLD_COUNT] = 1'b1;
          end
        end
      end else begin
        s_d.i_run = '0;
        i_done = (s_q.instr_r.hresp == profiler_pkg::RESP_OKAY) ||
                 (s_q.instr_r.hresp == profiler_pkg::RESP_ERROR);
      end
    end else begin
      s_d.i_run = '0;
    end
    if (i_done) begin
      inc[profiler_pkg::C_INSTR_READ_COUNT] = 1'b1;
      if (s_q.i_dp_first) begin
        unique case (s_q.i_dp_burst)
          profiler_pkg::BURST_SINGLE:
            inc[profiler_pkg::C_INSTR_SINGLE_BURST_COUNT] = 1'b1;
          profiler_pkg::BURST_INCR4:
            inc[profiler_pkg::C_INSTR_INCR4_BURST_COUNT] = 1'b1;
          profiler_pkg::BURST_WRAP8:
            inc[profiler_pkg::C_INSTR_LINE_FILL_COUNT] = 1'b1;
          default: ;
        endcase
      end
    end
    if (s_q.instr_r.hready) begin
      s_d.i_dp_valid = s_q.instr_r.htrans == profiler_pkg::TRANS_NONSEQ ||
                       s_q.instr_r.htrans == profiler_pkg::TRANS_SEQ;
      s_d.i_dp_first = s_q.instr_r.htrans == profiler_pkg::TRANS_NONSEQ;
      s_d.i_dp_burst = s_q.instr_r.hburst;
    end

    // ------------------------------------------------------------------
    // Peripheral DMA layer
    // ------------------------------------------------------------------
    if (s_q.d_dp_valid && s_q.dma_r.hready) begin
      d_done = (s_q.dma_r.hresp == profiler_pkg::RESP_OKAY) ||
               (s_q.dma_r.hresp == profiler_pkg::RESP_ERROR);
    end
    if (d_done) begin
      if (s_q.d_dp_write) begin
        inc[profiler_pkg::C_DMA_WRITE_COUNT] = 1'b1;
      end else begin
        inc[profiler_pkg::C_DMA_READ_COUNT] = 1'b1;
      end
      unique case (s_q.d_dp_slave)
        profiler_pkg::SLV_UART: inc[profiler_pkg::C_DMA_UART_COUNT] = 1'b1;
        profiler_pkg::SLV_SCI:  inc[profiler_pkg::C_DMA_SCI_COUNT]  = 1'b1;
        profiler_pkg::SLV_SSP:  inc[profiler_pkg::C_DMA_SSP_COUNT]  = 1'b1;
        default: ;
      endcase
    end
    if (s_q.dma_r.hready) begin
      s_d.d_dp_valid = s_q.dma_r.htrans == profiler_pkg::TRANS_NONSEQ ||
                       s_q.dma_r.htrans == profiler_pkg::TRANS_SEQ;
      s_d.d_dp_write = s_q.dma_r.hwrite;
      s_d.d_dp_slave = s_q.dma_r.slave_sel;
    end

    // ------------------------------------------------------------------
    // Split-transfer port
    // ------------------------------------------------------------------
    rd_addr_hs = s_q.split_r.addr_valid & s_q.split_r.addr_ready & ~s_q.split_r.addr_write;
    rd_data_hs = s_q.split_r.rdata_valid & s_q.split_r.rdata_ready;
    if (rd_addr_hs && !rd_data_hs && s_q.rd_out != 8'hFF) begin
      s_d.rd_out = s_q.rd_out + 8'h01;
    end else if (!rd_addr_hs && rd_data_hs && s_q.rd_out != 8'h00) begin
      s_d.rd_out = s_q.rd_out - 8'h01;
    end
    if (rd_data_hs) begin
      inc[profiler_pkg::C_SPLIT_READ_COUNT] = 1'b1;
    end
    if (s_q.split_r.addr_valid && s_q.split_r.addr_ready && s_q.split_r.addr_write) begin
      inc[profiler_pkg::C_SPLIT_WRITE_COUNT] = 1'b1;
    end
    if ((s_q.split_r.addr_valid && !s_q.split_r.addr_ready) ||
        (s_q.split_r.rdata_valid && !s_q.split_r.rdata_ready)) begin
      inc[profiler_pkg::C_SPLIT_STALL_COUNT] = 1'b1;
    end

    // Read channel field
    if (rd_data_hs) begin
      s_d.dbg[3:2] = (s_q.rd_out > 8'h01) ? profiler_pkg::RD_XFER_MORE
                                          : profiler_pkg::RD_XFER_NONE;
    end else if (s_q.rd_out != 8'h00) begin
      s_d.dbg[3:2] = profiler_pkg::RD_WAIT_PENDING;
    end else begin
      s_d.dbg[3:2] = profiler_pkg::RD_IDLE;
    end
    // Address channel field
    if (!s_q.split_r.addr_valid) begin
      s_d.dbg[1:0] = profiler_pkg::AD_IDLE;
    end else if (!s_q.split_r.addr_ready) begin
      s_d.dbg[1:0] = profiler_pkg::AD_WAIT;
    end else if (s_q.split_r.addr_write) begin
      s_d.dbg[1:0] = profiler_pkg::AD_WRITE;
    end else begin
      s_d.dbg[1:0] = profiler_pkg::AD_READ;
    end

    // ------------------------------------------------------------------
    // Counter update
    // ------------------------------------------------------------------
    for (int i = 0; i < profiler_pkg::NCNT; i++) begin
      cnt_en[i] = (i <= profiler_pkg::C_INSTR_WAIT_THRESHOLD_COUNT) ? i_en : g_en;
      if (s_q.preset_pend) begin
        s_d.cnt[i] = preset_val[i];
      end else if (s_q.clear_pend) begin
        s_d.cnt[i] = '0;
      end else if (inc[i] && cnt_en[i]) begin
        s_d.cnt[i] = s_q.cnt[i] + 32'h00000001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q            <= '0;
      s_q.ctrl       <= profiler_pkg::CTRL_RST;
      s_q.ctrl_eff   <= profiler_pkg::CTRL_RST;
      s_q.thresh     <= profiler_pkg::THRESH_RST;
      s_q.thresh_eff <= profiler_pkg::THRESH_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o               = s_q.ack;
  assign wb_dat_o               = s_q.rdata;
  assign bus_state_debug_port_o = s_q.dbg;

endmodule // bus_activity_profiler

// ---- hdl/profiler_pkg.sv ----
// Constants, carrier structs and state layout of the bus activity profiler.
// Assumes one 125 MHz bus clock shared by the monitored layers and Wishbone.
package profiler_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [31:0] MON_BASE_ADDR = 32'h101D0000;
  localparam int          ADR_W         = 12;
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_THRESH    = 12'h004;
  localparam logic [11:0] OFS_CLEAR     = 12'h008;
  localparam logic [11:0] OFS_PRESET    = 12'h00C;
  localparam logic [11:0] OFS_DEBUG     = 12'h010;
  localparam logic [3:0]  CNT_PAGE      = 4'h1;
  localparam logic [11:0] OFS_CNT_BASE  = 12'h100;
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          CTRL_TRACK_BIT = 1;
  localparam logic [1:0]  CTRL_RST       = 2'h0;
  localparam int          THRESH_W       = 16;
  localparam logic [15:0] THRESH_RST     = 16'h0004;

  // ----------------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [1:0] TRANS_SEQ    = 2'h3;
  localparam logic [2:0] BURST_SINGLE = 3'h0;
  localparam logic [2:0] BURST_INCR4  = 3'h3;
  localparam logic [2:0] BURST_WRAP8  = 3'h4;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_ERROR   = 2'h1;
  localparam logic [1:0] SLV_UART     = 2'h1;
  localparam logic [1:0] SLV_SCI      = 2'h2;
  localparam logic [1:0] SLV_SSP      = 2'h3;

  // Debug state codes
  localparam logic [1:0] RD_IDLE         = 2'h0;
  localparam logic [1:0] RD_WAIT_PENDING = 2'h1;
  localparam logic [1:0] RD_XFER_NONE    = 2'h2;
  localparam logic [1:0] RD_XFER_MORE    = 2'h3;
  localparam logic [1:0] AD_IDLE         = 2'h0;
  localparam logic [1:0] AD_WAIT         = 2'h1;
  localparam logic [1:0] AD_READ         = 2'h2;
  localparam logic [1:0] AD_WRITE        = 2'h3;

  // ----------------------------------------------------------------------
  // Counter indices
  // ----------------------------------------------------------------------
  localparam int CNT_W                          = 32;
  localparam int NCNT                           = 16;
  localparam int C_INSTR_READ_COUNT             = 0;
  localparam int C_INSTR_SINGLE_BURST_COUNT     = 1;
  localparam int C_INSTR_INCR4_BURST_COUNT      = 2;
  localparam int C_INSTR_LINE_FILL_COUNT        = 3;
  localparam int C_INSTR_WAIT_TOTAL_COUNT       = 4;
  localparam int C_INSTR_FIRST_WAIT_SLAVE_COUNT = 5;
  localparam int C_INSTR_FIRST_WAIT_FABRIC_COUNT = 6;
  localparam int C_INSTR_WAIT_THRESHOLD_COUNT   = 7;
  localparam int C_SPLIT_READ_COUNT             = 8;
  localparam int C_SPLIT_WRITE_COUNT            = 9;
  localparam int C_SPLIT_STALL_COUNT            = 10;
  localparam int C_DMA_READ_COUNT               = 11;
  localparam int C_DMA_WRITE_COUNT              = 12;
  localparam int C_DMA_UART_COUNT               = 13;
  localparam int C_DMA_SCI_COUNT                = 14;
  localparam int C_DMA_SSP_COUNT                = 15;

  // ----------------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] htrans;
    logic [2:0] hburst;
    logic       hwrite;
    logic       hready;
    logic [1:0] hresp;
    logic       slave_ready;
    logic [1:0] slave_sel;
  } ahb_mon_s;

  typedef struct packed {
    logic addr_valid;
    logic addr_ready;
    logic addr_write;
    logic rdata_valid;
    logic rdata_ready;
  } split_mon_s;

  typedef struct packed {
    ahb_mon_s                     instr_r;
    ahb_mon_s                     dma_r;
    split_mon_s                   split_r;
    logic                         debug_acknowledge_r;
    logic [1:0]                   ctrl;
    logic [1:0]                   ctrl_eff;
    logic [THRESH_W-1:0]          thresh;
    logic [THRESH_W-1:0]          thresh_eff;
    logic                         clear_pend;
    logic                         preset_pend;
    logic                         i_dp_valid;
    logic                         i_dp_first;
    logic [2:0]                   i_dp_burst;
    logic [THRESH_W-1:0]          i_run;
    logic                         d_dp_valid;
    logic                         d_dp_write;
    logic [1:0]                   d_dp_slave;
    logic [7:0]                   rd_out;
    logic [3:0]                   dbg;
    logic                         ack;
    logic [31:0]                  rdata;
    logic [NCNT-1:0][CNT_W-1:0]   cnt;
  } prof_state_s;

endpackage

// ---- tb/bus_activity_profiler_assertions.sv ----
// Checker for the profiler's register bus answers and debug state port.
// Bound into every bus_activity_profiler; one clock, synchronous reset.
`timescale 1ns/100ps
module bus_activity_profiler_assertions (
  input wire logic                           clk_i,
  input wire logic                           rst_i,
  input wire logic                           wb_cyc_i,
  input wire logic                           wb_stb_i,
  input wire logic                           wb_we_i,
  input wire logic [profiler_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0]                    wb_dat_o,
  input wire logic                           wb_ack_o,
  input wire profiler_pkg::split_mon_s       split_transfer_port_i,
  input wire logic [3:0]                     bus_state_debug_port_o
);
  // --------------------------------------------------------------------
  // Outstanding split reads and properties
  // --------------------------------------------------------------------
  logic [7:0] out_q;
  logic       ahs;
  logic       dhs;
  logic       take;
  assign ahs  = split_transfer_port_i.addr_valid && split_transfer_port_i.addr_ready;
  assign dhs  = split_transfer_port_i.rdata_valid && split_transfer_port_i.rdata_ready;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) out_q <= 8'h00;
    else out_q <= out_q + 8'(ahs && !split_transfer_port_i.addr_write) - 8'(dhs);
  end
  function automatic logic [1:0] rd_exp(input logic h, input logic [7:0] o);
    return h ? ((o > 8'h01) ? 2'h3 : 2'h2) : ((o != 8'h00) ? 2'h1 : 2'h0);
  endfunction
  function automatic logic [1:0] ad_exp(input profiler_pkg::split_mon_s s);
    return !s.addr_valid ? 2'h0 : !s.addr_ready ? 2'h1 : s.addr_write ? 2'h3 : 2'h2;
  endfunction
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_LATENCY: assert property (take |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack cycle");
  AST_UNALIGNED: assert property (
    take && !wb_we_i && wb_adr_i[1:0] != 2'h0 |=> wb_dat_o == 32'h0)
    else $error("unaligned read returned data");
  AST_UNMAPPED: assert property (
    take && !wb_we_i && wb_adr_i inside {[12'h014:12'h0FC]} |=> wb_dat_o == 32'h0)
    else $error("unmapped read returned data");
  AST_ADDR_FIELD: assert property (
    bus_state_debug_port_o[1:0] == ad_exp($past(split_transfer_port_i, 2)))
    else $error("address channel state wrong");
  AST_READ_FIELD: assert property (
    bus_state_debug_port_o[3:2] == rd_exp($past(dhs, 2), $past(out_q, 2)))
    else $error("read channel state wrong");
  AST_RESET_QUIET: assert property ($fell(rst_i) |-> !wb_ack_o && bus_state_debug_port_o == 4'h0)
    else $error("outputs active after reset");
  cover property (take && wb_we_i);
  cover property (bus_state_debug_port_o[1:0] == 2'h3);
  cover property (bus_state_debug_port_o[3:2] == 2'h3);
endmodule // bus_activity_profiler_assertions

bind bus_activity_profiler bus_activity_profiler_assertions u_bus_activity_profiler_assertions (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .split_transfer_port_i(split_transfer_port_i), .bus_state_debug_port_o(bus_state_debug_port_o)
);

// ---- tb/bus_activity_profiler_test.sv ----
// Self-checking bench for the bus activity profiler.
// Drives Wishbone itself and the monitored layers through bus_partner.
`timescale 1ns/100ps
module bus_activity_profiler_test;
  // --------------------------------------------------------------------
  // Signals, tasks and scenarios
  // --------------------------------------------------------------------
  logic                     clk_i;
  logic                     rst_i;
  logic                     wb_cyc, wb_stb, wb_we, wb_ack, dbg_ack;
  logic [11:0]              wb_adr;
  logic [3:0]               wb_sel, dbg_port;
  logic [31:0]              wb_dat, wb_rdat, rd;
  profiler_pkg::ahb_mon_s   instr, dma;
  profiler_pkg::split_mon_s split;
  int                       err_count = 0;
  int                       num_checks = 0;
  bus_activity_profiler u_bus_activity_profiler (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .instr_bus_i(instr), .debug_acknowledge_i(dbg_ack), .dma_bus_i(dma),
    .split_transfer_port_i(split), .bus_state_debug_port_o(dbg_port));
  bus_partner u_bus_partner (.clk_i(clk_i), .instr_o(instr), .dma_o(dma), .split_o(split));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_dat} <= {2'b11, w, 4'hF, a, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    {wb_cyc, wb_stb} <= 2'b00;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic cnt(input int i, input logic [31:0] e);
    rchk(12'h100 + 12'(4 * i), e);
  endtask
  task automatic t_reset;
    rchk(12'h000, 32'h0);
    rchk(12'h004, 32'h4);
    u_bus_partner.instr_xfer(3'h0, 1, 0, 1'b1, 2'h0);
    repeat (4) @(posedge clk_i);
    cnt(0, 32'h0);
    rchk(12'h102, 32'h0);
    rchk(12'h0F0, 32'h0);
  endtask
  task automatic t_preset;
    wb(1'b1, 12'h00C, 32'h0);
    for (int i = 0; i < 16; i++) begin
      cnt(i, profiler_pkg::MON_BASE_ADDR + 32'h100 + 32'(4 * i));
    end
    wb(1'b1, 12'h008, 32'h0);
    for (int i = 0; i < 16; i++) cnt(i, 32'h0);
  endtask
  task automatic t_instr;
    logic [31:0] e [8];
    e = '{32'hE, 32'h2, 32'h1, 32'h1, 32'h9, 32'h5, 32'h4, 32'h1};
    wb(1'b1, 12'h000, 32'h1);
    u_bus_partner.instr_xfer(profiler_pkg::BURST_SINGLE, 1, 5, 1'b0, 2'h0);
    u_bus_partner.instr_xfer(profiler_pkg::BURST_INCR4, 4, 4, 1'b1, 2'h0);
    u_bus_partner.instr_xfer(profiler_pkg::BURST_WRAP8, 8, 0, 1'b1, 2'h0);
    u_bus_partner.instr_xfer(3'h0, 1, 0, 1'b1, profiler_pkg::RESP_ERROR);
    u_bus_partner.instr_xfer(3'h0, 1, 0, 1'b1, 2'h2);
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 8; i++) cnt(i, e[i]);
    wb(1'b1, 12'h008, 32'h0);
    u_bus_partner.instr_xfer(3'h0, 1, 0, 1'b1, 2'h0);
    repeat (4) @(posedge clk_i);
    cnt(0, 32'h1);
  endtask
  task automatic t_track;
    wb(1'b1, 12'h008, 32'h0);
    wb(1'b1, 12'h004, 32'h2);
    wb(1'b1, 12'h000, 32'h3);
    dbg_ack <= 1'b1;
    u_bus_partner.instr_xfer(3'h0, 1, 3, 1'b0, 2'h0);
    repeat (4) @(posedge clk_i);
    dbg_ack <= 1'b0;
    u_bus_partner.instr_xfer(3'h0, 1, 3, 1'b0, 2'h0);
    repeat (4) @(posedge clk_i);
    cnt(0, 32'h1);
    cnt(7, 32'h1);
  endtask
  task automatic t_layers;
    logic [31:0] e [5];
    e = '{32'h2, 32'h2, 32'h1, 32'h1, 32'h1};
    wb(1'b1, 12'h008, 32'h0);
    for (int s = 0; s < 4; s++) u_bus_partner.dma_xfer(s[0], 2'(s));
    u_bus_partner.split_hs(5'b10000, 5'b11000);
    u_bus_partner.split_hs(5'b10000, 5'b11000);
    u_bus_partner.split_hs(5'b00010, 5'b00011);
    u_bus_partner.split_hs(5'b00010, 5'b00011);
    u_bus_partner.split_hs(5'b10100, 5'b11100);
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 5; i++) cnt(11 + i, e[i]);
    cnt(8, 32'h2);
    cnt(9, 32'h1);
    cnt(10, 32'h5);
    u_bus_partner.split_hs(5'b10000, 5'b11000);
    u_bus_partner.split_hold(5'b10000);
    repeat (2) @(posedge clk_i);
    rchk(12'h010, 32'h5);
  endtask
  task automatic summarize;
    $display("errors %0d of %0d checks", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    {rst_i, wb_cyc, wb_stb, wb_we, dbg_ack} = 5'b10000;
    wb_adr = 12'h000;
    wb_sel = 4'hF;
    wb_dat = 32'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_preset();
    t_instr();
    t_track();
    t_layers();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    summarize();
  end
endmodule // bus_activity_profiler_test

// ---- tb/bus_partner.sv ----
// Behavioural masters and slaves on the monitored layers.
// Bench calls its tasks; outputs change just after clk_i rises.
`timescale 1ns/100ps
module bus_partner (
  input  wire logic                clk_i,
  output profiler_pkg::ahb_mon_s   instr_o,
  output profiler_pkg::ahb_mon_s   dma_o,
  output profiler_pkg::split_mon_s split_o
);
  // --------------------------------------------------------------------
  // Layer tasks
  // --------------------------------------------------------------------
  initial begin
    instr_o = '{2'h0, 3'h0, 1'b0, 1'b1, 2'h0, 1'b1, 2'h0};
    dma_o   = instr_o;
    split_o = 5'b00000;
  end
  task automatic beat(input logic [1:0] t, input logic [2:0] b, input logic rdy,
                      input logic srdy, input logic [1:0] r);
    @(posedge clk_i);
    instr_o <= '{t, b, 1'b0, rdy, r, srdy, 2'h0};
  endtask
  task automatic instr_xfer(input logic [2:0] b, input int beats, input int waits,
                            input logic srdy, input logic [1:0] resp);
    logic [1:0] t;
    for (int i = 0; i <= beats; i++) begin
      t = (i == beats) ? 2'h0 : (i == 0) ? profiler_pkg::TRANS_NONSEQ : profiler_pkg::TRANS_SEQ;
      if (i == 1) repeat (waits) beat(t, b, 1'b0, srdy, 2'h0);
      if (i == beats && resp != 2'h0) beat(t, b, 1'b0, 1'b1, resp);
      beat(t, b, 1'b1, 1'b1, (i == beats) ? resp : 2'h0);
    end
    beat(2'h0, b, 1'b1, 1'b1, 2'h0);
  endtask
  task automatic dma_xfer(input logic w, input logic [1:0] s);
    @(posedge clk_i);
    dma_o <= '{profiler_pkg::TRANS_NONSEQ, 3'h0, w, 1'b1, 2'h0, 1'b1, s};
    @(posedge clk_i);
    dma_o <= '{2'h0, 3'h0, !w, 1'b1, 2'h0, 1'b1, ~s};
  endtask
  task automatic split_hs(input profiler_pkg::split_mon_s wait_v,
                          input profiler_pkg::split_mon_s go_v);
    @(posedge clk_i);
    split_o <= wait_v;
    @(posedge clk_i);
    split_o <= go_v;
    @(posedge clk_i);
    split_o <= '{1'b0, 1'b0, !go_v.addr_write, 1'b0, 1'b0};
  endtask
  task automatic split_hold(input profiler_pkg::split_mon_s v);
    @(posedge clk_i);
    split_o <= v;
  endtask
endmodule // bus_partner
